// >>> spc_map.svh
// register offsets, field positions, reset values and timing constants
// for the sector protection block; definitions only
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

// register byte offsets
`define SPC_OFS_SOW     4'h0
`define SPC_OFS_STATUS  4'h4
`define SPC_OFS_CMD     4'h8
`define SPC_OFS_SECSEL  4'hC

// security option word fields
`define SPC_SOW_RESET   16'hFEFF
`define SPC_SOW_TRAP    13
`define SPC_SOW_HYBRID  11
`define SPC_SOW_DED     9
`define SPC_SOW_RDPW    5
`define SPC_SOW_PWLK    2
`define SPC_SOW_PSLK    1

// status word fields
`define SPC_ST_BUSY     0
`define SPC_ST_SLOCK    1
`define SPC_ST_PFAIL    4
`define SPC_ST_EFAIL    5

// command codes (cmd register bits 3:0)
`define SPC_CMD_NONE    4'h0
`define SPC_CMD_VSET    4'h1
`define SPC_CMD_VCLR    4'h2
`define SPC_CMD_PPROG   4'h3
`define SPC_CMD_PERASE  4'h4
`define SPC_CMD_LKCLR   4'h5
`define SPC_CMD_SOWPROG 4'h6
`define SPC_CMD_UNLOCK  4'h7
`define SPC_CMD_ARRPROG 4'h8
`define SPC_CMD_ARRERAS 4'h9
`define SPC_CMD_CLRST   4'hA

// word-program time, ns
`define SPC_TWORD_NS    500000
`define SPC_CLK_NS      4
`define SPC_TWORD_CYC   (`SPC_TWORD_NS / `SPC_CLK_NS)

`endif

// >>> spc_pkg.sv
// types for the sector protection block
package spc_pkg;
  typedef enum logic [1:0] {
    SPC_IDLE,
    SPC_BUSY,
    SPC_DONE
  } spc_state_t;
endpackage

// >>> spc_sector_protect.sv
// sector protection state and security option word of a serial nor flash
// assumes an avalon-mm master on one 250 mhz clock, sync reset = hw reset
//
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "spc_map.svh"

module spc_sector_protect
  import spc_pkg::*;
#(
  parameter int NSECT     = 32,
  parameter int TWORD_CYC = `SPC_TWORD_CYC
) (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  // avalon-mm slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // hidden password, held in separate non-volatile storage
  input  wire logic [63:0] i_password,
  // decoded options
  output logic             o_trap_single,
  output logic             o_hybrid_burst,
  output logic             o_ded_enable,
  output logic             o_read_pw_mode,
  output logic             o_password_mode,
  output logic             o_lock_flag
);

  localparam int SW = $clog2(NSECT);
  localparam int CW = $clog2(TWORD_CYC + 1);

  if (NSECT < 2 || NSECT > 32) begin : g_nsect_chk
    $error("NSECT must be 2..32");
  end
  if (TWORD_CYC < 1) begin : g_tword_chk
    $error("TWORD_CYC must be at least 1");
  end

  // non-volatile state: kept over reset
  logic [NSECT-1:0] persistent_sector_lock_r;
  logic [15:0]      security_option_word_r;
  logic             nv_init_r = 1'b0;
  // volatile state
  logic [NSECT-1:0] volatile_sector_lock_r;
  logic             lock_flag_r;
  logic [7:0]       operation_status_word_r;
  logic [SW-1:0]    sector_r;
  logic [63:0]      pw_try_r;
  spc_state_t       state_r;
  logic [CW-1:0]    cnt_r;
  logic [3:0]       op_r;
  logic [15:0]      op_data_r;
  logic             op_ok_r;
  logic             slock_r;

  logic             password_mode;
  logic             mode_locked;
  logic             sec_unprot;
  logic             acc;
  logic             wr_cmd;
  logic [3:0]       cmd;

  assign password_mode = (security_option_word_r[`SPC_SOW_PSLK+:2]
                          == 2'b01);
  assign mode_locked   = (security_option_word_r[`SPC_SOW_PSLK+:2]
                          != 2'b11);
  // unprotected only if both bits one, flag plays no part
  assign sec_unprot = persistent_sector_lock_r[sector_r]
                      & volatile_sector_lock_r[sector_r];
  assign acc    = (i_avs_read | i_avs_write) & o_avs_waitrequest;
  assign cmd    = i_avs_writedata[3:0];
  assign wr_cmd = i_avs_write & o_avs_waitrequest
                  & (i_avs_address == `SPC_OFS_CMD)
                  & (state_r == SPC_IDLE);

  // bus answer: one wait cycle, then ack
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= ~acc;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read & o_avs_waitrequest) begin
      unique case (i_avs_address)
        `SPC_OFS_SOW:    o_avs_readdata <= {16'h0000,
                                            security_option_word_r};
        `SPC_OFS_STATUS: o_avs_readdata <= {24'h00_0000,
                                            operation_status_word_r};
        `SPC_OFS_CMD:    o_avs_readdata <= {27'h000_0000,
                                            sec_unprot, lock_flag_r,
                                            password_mode, mode_locked,
                                            state_r != SPC_IDLE};
        `SPC_OFS_SECSEL: o_avs_readdata <= {14'h0000,
                           persistent_sector_lock_r[sector_r],
                           volatile_sector_lock_r[sector_r],
                           11'h000, 5'(sector_r)};
        default:         o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // sector select and password staging
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      sector_r <= '0;
      pw_try_r <= 64'hFFFF_FFFF_FFFF_FFFF;
    end else if (i_avs_write & o_avs_waitrequest
                 & (i_avs_address == `SPC_OFS_SECSEL)) begin
      sector_r <= i_avs_writedata[SW-1:0];
      if (i_avs_writedata[31])
        pw_try_r <= {pw_try_r[47:0], i_avs_writedata[15:0]};
    end
  end

  // operation sequencer: commands other than none and the status clear take a word-program time
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_r   <= SPC_IDLE;
      cnt_r     <= '0;
      op_r      <= `SPC_CMD_NONE;
      op_data_r <= 16'hFFFF;
    end else begin
      unique case (state_r)
        SPC_IDLE: if (wr_cmd && cmd != `SPC_CMD_NONE
                      && cmd != `SPC_CMD_CLRST) begin
          state_r   <= SPC_BUSY;
          op_r      <= cmd;
          op_data_r <= i_avs_writedata[31:16];
          cnt_r     <= CW'(TWORD_CYC - 1);
        end
        SPC_BUSY: if (cnt_r == '0) state_r <= SPC_DONE;
                  else cnt_r <= cnt_r - 1'b1;
        SPC_DONE: state_r <= SPC_IDLE;
        default:  state_r <= SPC_IDLE;
      endcase
    end
  end

  // decide the outcome of the pending operation
  always_comb begin
    op_ok_r = 1'b1;
    slock_r = 1'b0;
    unique case (op_r)
      `SPC_CMD_PPROG, `SPC_CMD_PERASE: begin
        op_ok_r = lock_flag_r;
        slock_r = ~lock_flag_r;
      end
      `SPC_CMD_SOWPROG: begin
        // both mode bits at once, or already frozen
        op_ok_r = ~mode_locked & (op_data_r[`SPC_SOW_PSLK+:2]
                                  != 2'b00);
        slock_r = ~op_ok_r;
      end
      `SPC_CMD_UNLOCK: begin
        op_ok_r = password_mode & (pw_try_r == i_password);
        slock_r = ~op_ok_r;
      end
      `SPC_CMD_ARRPROG, `SPC_CMD_ARRERAS: begin
        op_ok_r = sec_unprot;
        slock_r = ~sec_unprot;
      end
      default: ;
    endcase
  end

  // status word; hardware set wins over software clear
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      operation_status_word_r <= 8'h00;
    end else begin
      if (wr_cmd && cmd == `SPC_CMD_CLRST)
        operation_status_word_r <= 8'h00;
      operation_status_word_r[`SPC_ST_BUSY] <= (state_r == SPC_BUSY)
                                            | (wr_cmd && cmd != `SPC_CMD_NONE
                                               && cmd != `SPC_CMD_CLRST);
      if (state_r == SPC_DONE && !op_ok_r) begin
        operation_status_word_r[`SPC_ST_SLOCK] <= slock_r;
        if (op_r == `SPC_CMD_PERASE || op_r == `SPC_CMD_ARRERAS)
          operation_status_word_r[`SPC_ST_EFAIL] <= 1'b1;
        else
          operation_status_word_r[`SPC_ST_PFAIL] <= 1'b1;
      end
    end
  end

  // non-volatile words: only loaded once, never by reset
  always_ff @(posedge i_clock) begin
    if (!nv_init_r) begin
      persistent_sector_lock_r <= '1;
      security_option_word_r   <= `SPC_SOW_RESET;
    end else if (state_r == SPC_DONE && op_ok_r) begin
      unique case (op_r)
        `SPC_CMD_PPROG:
          persistent_sector_lock_r[sector_r] <= 1'b0;
        `SPC_CMD_PERASE:
          persistent_sector_lock_r <= '1;
        `SPC_CMD_SOWPROG:
          security_option_word_r <= security_option_word_r
                                    & op_data_r;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    nv_init_r <= 1'b1;
  end

  // volatile locks: back to one at every reset
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      volatile_sector_lock_r <= '1;
    end else if (state_r == SPC_DONE && op_r == `SPC_CMD_VSET) begin
      volatile_sector_lock_r[sector_r] <= 1'b0;
    end else if (state_r == SPC_DONE && op_r == `SPC_CMD_VCLR) begin
      volatile_sector_lock_r[sector_r] <= 1'b1;
    end
  end

  // global lock flag
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      lock_flag_r <= ~password_mode;
    end else if (state_r == SPC_DONE && op_r == `SPC_CMD_LKCLR) begin
      lock_flag_r <= 1'b0;
    end else if (state_r == SPC_DONE && op_r == `SPC_CMD_UNLOCK
                 && op_ok_r) begin
      lock_flag_r <= 1'b1;
    end
  end

  // decoded option outputs
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_trap_single   <= 1'b0;
      o_hybrid_burst  <= 1'b0;
      o_ded_enable    <= 1'b0;
      o_read_pw_mode  <= 1'b0;
      o_password_mode <= 1'b0;
      o_lock_flag     <= 1'b0;
    end else begin
      o_trap_single   <= ~security_option_word_r[`SPC_SOW_TRAP];
      o_hybrid_burst  <= ~security_option_word_r[`SPC_SOW_HYBRID];
      o_ded_enable    <= ~security_option_word_r[`SPC_SOW_DED];
      o_read_pw_mode  <= ~security_option_word_r[`SPC_SOW_RDPW];
      o_password_mode <= password_mode;
      o_lock_flag     <= lock_flag_r;
    end
  end

  // busy period length, counted for the length check
  logic [CW-1:0]    busy_len_r;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      busy_len_r <= '0;
    end else if (state_r == SPC_BUSY) begin
      busy_len_r <= busy_len_r + 1'b1;
    end else begin
      busy_len_r <= '0;
    end
  end

  // checks
  persist_guard_a: assert property (
    @(posedge i_clock) disable iff (i_srst)
    !lock_flag_r && state_r == SPC_DONE
    |=> $stable(persistent_sector_lock_r))
    else $error("persistent lock changed with flag zero");
  sow_abort_a: assert property (
    @(posedge i_clock) disable iff (i_srst)
    state_r == SPC_DONE && op_r == `SPC_CMD_SOWPROG && mode_locked
    |=> operation_status_word_r[`SPC_ST_PFAIL]
        && operation_status_word_r[`SPC_ST_SLOCK]
        && $stable(security_option_word_r))
    else $error("frozen option word program not aborted");
  both_bits_a: assert property (
    @(posedge i_clock) disable iff (i_srst)
    state_r == SPC_DONE && op_r == `SPC_CMD_SOWPROG
    && op_data_r[`SPC_SOW_PSLK+:2] == 2'b00
    |=> operation_status_word_r[`SPC_ST_PFAIL]
        && operation_status_word_r[`SPC_ST_SLOCK]
        && $stable(security_option_word_r))
    else $error("both mode bits programmed");
  vol_reset_a: assert property (
    @(posedge i_clock)
    i_srst |=> volatile_sector_lock_r == '1)
    else $error("volatile lock kept over reset");
  flag_reset_a: assert property (
    @(posedge i_clock)
    i_srst && nv_init_r |=> lock_flag_r == ~$past(password_mode))
    else $error("lock flag reset value wrong");
  arr_abort_a: assert property (
    @(posedge i_clock) disable iff (i_srst)
    state_r == SPC_DONE && op_r == `SPC_CMD_ARRPROG && !sec_unprot
    |=> operation_status_word_r[`SPC_ST_SLOCK]
        && operation_status_word_r[`SPC_ST_PFAIL])
    else $error("protected sector program not aborted");
  sow_otp_a: assert property (
    @(posedge i_clock)
    $past(nv_init_r) |->
    (security_option_word_r & ~$past(security_option_word_r)) == 16'h0000)
    else $error("option word bit went back to one");
  unlock_a: assert property (
    @(posedge i_clock) disable iff (i_srst)
    !$past(i_srst) && !$past(lock_flag_r) && lock_flag_r
    |-> $past(op_r) == `SPC_CMD_UNLOCK && $past(password_mode)
        && $past(pw_try_r) == $past(i_password))
    else $error("lock flag set without password");
  busy_len_a: assert property (
    @(posedge i_clock) disable iff (i_srst)
    state_r == SPC_DONE |-> busy_len_r == CW'(TWORD_CYC))
    else $error("busy period length wrong");
  arr_erase_a: assert property (
    @(posedge i_clock) disable iff (i_srst)
    state_r == SPC_DONE && op_r == `SPC_CMD_ARRERAS && !sec_unprot
    |=> operation_status_word_r[`SPC_ST_EFAIL]
        && operation_status_word_r[`SPC_ST_SLOCK])
    else $error("protected sector erase not aborted");
  vol_change_a: assert property (
    @(posedge i_clock) disable iff (i_srst)
    state_r == SPC_DONE && op_r == `SPC_CMD_VSET
    |=> !volatile_sector_lock_r[$past(sector_r)])
    else $error("volatile lock set refused");
  flag_clear_a: assert property (
    @(posedge i_clock) disable iff (i_srst)
    state_r == SPC_DONE && op_r == `SPC_CMD_LKCLR |=> !lock_flag_r)
    else $error("lock flag not cleared");
  pers_abort_a: assert property (
    @(posedge i_clock) disable iff (i_srst)
    state_r == SPC_DONE && op_r == `SPC_CMD_PERASE && !lock_flag_r
    |=> operation_status_word_r[`SPC_ST_EFAIL])
    else $error("persistent erase with flag zero not reported");
  sow_frozen_a: assert property (
    @(posedge i_clock) disable iff (i_srst)
    mode_locked |=> $stable(security_option_word_r))
    else $error("frozen option word changed");
  opt_decode_a: assert property (
    @(posedge i_clock) disable iff (i_srst)
    !$past(i_srst)
    |-> o_trap_single == !$past(security_option_word_r[`SPC_SOW_TRAP])
        && o_hybrid_burst == !$past(security_option_word_r[`SPC_SOW_HYBRID])
        && o_ded_enable == !$past(security_option_word_r[`SPC_SOW_DED])
        && o_read_pw_mode == !$past(security_option_word_r[`SPC_SOW_RDPW]))
    else $error("option outputs do not follow the word");
  unlocked_rst_a: assert property (
    @(posedge i_clock) disable iff (i_srst)
    $past(i_srst) && persistent_sector_lock_r[sector_r] |-> sec_unprot)
    else $error("unlocked sector protected after reset");

endmodule // spc_sector_protect

// >>> spc_host_model.sv
// avalon-mm host issuing command sequences to the protection block
// assumes one clock; xfer is entered right after a rising edge
`timescale 1ns/1ps

module spc_host_model (
  // clock
  input  wire logic        i_clock,
  // slave answer
  input  wire logic        i_waitrequest,
  input  wire logic [31:0] i_readdata,
  // request
  output logic [3:0]       o_address,
  output logic             o_read,
  output logic             o_write,
  output logic [31:0]      o_writedata
);
  initial begin
    o_address   = 4'h0;
    o_read      = 1'b0;
    o_write     = 1'b0;
    o_writedata = 32'h0;
  end

  task automatic xfer(input logic w, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    o_address   <= a;
    o_writedata <= d;
    o_write     <= w;
    o_read      <= ~w;
    @(posedge i_clock);
    while (i_waitrequest !== 1'b0) begin
      @(posedge i_clock);
    end
    q = i_readdata;
    o_write     <= 1'b0;
    o_read      <= 1'b0;
    o_writedata <= ~d;
    @(posedge i_clock);
  endtask
endmodule // spc_host_model

// >>> tb.sv
// self-checking bench: model of locks and option word against the block
// assumes TWORD_CYC shortened to 8 and 32 sectors
`timescale 1ns/1ps
`include "spc_map.svh"

module tb
  import spc_pkg::*;
;
  localparam int NS = 32;
  logic i_clock, i_srst, rd, wr, wreq, o1, o2, o3, o4, o5, lk;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, seed;
  logic [63:0] i_password, pw_in;
  logic [15:0] sow, v;
  logic [NS-1:0] persistent_sector_lock, volatile_sector_lock;
  logic [7:0]  st;
  logic        flag;
  int s, n_mismatch, total_checks;

  spc_host_model host (.i_clock(i_clock), .i_waitrequest(wreq),
    .i_readdata(rdata), .o_address(addr), .o_read(rd), .o_write(wr),
    .o_writedata(wdata));
  spc_sector_protect #(.NSECT(NS), .TWORD_CYC(8)) u_dut (
    .i_clock(i_clock), .i_srst(i_srst), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_password(i_password), .o_trap_single(o1), .o_hybrid_burst(o2),
    .o_ded_enable(o3), .o_read_pw_mode(o4), .o_password_mode(o5),
    .o_lock_flag(lk));

  always #2 i_clock = ~i_clock;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic hw_reset(input int n);
    i_srst <= 1'b1;
    repeat (n) @(posedge i_clock);
    i_srst <= 1'b0;
    @(posedge i_clock);
    volatile_sector_lock  = '1;
    st   = 8'h00;
    flag = (sow[2:1] != 2'b01);
  endtask

  task automatic cmd(input logic [3:0] c, input logic [15:0] d);
    logic [31:0] q;
    logic        fail;
    fail = 1'b0;
    host.xfer(1'b1, `SPC_OFS_SECSEL, 32'(s), q);
    host.xfer(1'b1, `SPC_OFS_CMD, {d, 12'h0, c}, q);
    q = 32'h1;
    while (q[`SPC_ST_BUSY] !== 1'b0) begin
      host.xfer(1'b0, `SPC_OFS_STATUS, 32'h0, q);
    end
    case (c)
      `SPC_CMD_VSET: volatile_sector_lock[s] = 1'b0;
      `SPC_CMD_VCLR: volatile_sector_lock[s] = 1'b1;
      `SPC_CMD_PPROG: if (flag) persistent_sector_lock[s] = 1'b0; else fail = 1'b1;
      `SPC_CMD_PERASE: if (flag) persistent_sector_lock = '1; else fail = 1'b1;
      `SPC_CMD_LKCLR: flag = 1'b0;
      `SPC_CMD_SOWPROG: begin
        if (sow[2:1] != 2'b11 || d[2:1] == 2'b00)
          fail = 1'b1;
        else
          sow = sow & d;
      end
      `SPC_CMD_UNLOCK: if (sow[2:1] == 2'b01 && pw_in === i_password)
                         flag = 1'b1;
                       else fail = 1'b1;
      `SPC_CMD_ARRPROG, `SPC_CMD_ARRERAS: fail = ~(persistent_sector_lock[s] & volatile_sector_lock[s]);
      `SPC_CMD_CLRST: st = 8'h00;
      default: ;
    endcase
    if (fail)
      st = st | ((c == `SPC_CMD_PERASE || c == `SPC_CMD_ARRERAS) ?
                 8'h22 : 8'h12);
  endtask

  task automatic check_all;
    logic [31:0] q;
    host.xfer(1'b1, `SPC_OFS_SECSEL, 32'(s), q);
    host.xfer(1'b0, `SPC_OFS_STATUS, 32'h0, q);
    chk(q & 32'h32, {24'h0, st & 8'h32});
    host.xfer(1'b0, `SPC_OFS_SECSEL, 32'h0, q);
    chk({30'h0, q[17:16]}, {30'h0, persistent_sector_lock[s], volatile_sector_lock[s]});
    host.xfer(1'b0, `SPC_OFS_CMD, 32'h0, q);
    chk({28'h0, q[4:1]}, {28'h0, persistent_sector_lock[s] & volatile_sector_lock[s], flag,
        sow[2:1] == 2'b01, sow[2:1] != 2'b11});
    host.xfer(1'b0, `SPC_OFS_SOW, 32'h0, q);
    chk({16'h0, q[15:0]}, {16'h0, sow});
    chk({26'h0, o1, o2, o3, o4, o5, lk}, {26'h0, ~sow[13], ~sow[11],
        ~sow[9], ~sow[5], sow[2:1] == 2'b01, flag});
  endtask

  task automatic pw(input logic [63:0] p);
    logic [31:0] q;
    for (int i = 3; i >= 0; i--) begin  // words 3..0, most significant first
      host.xfer(1'b1, `SPC_OFS_SECSEL, {16'h8000, p[16*i +: 16]}, q);
    end
    pw_in = p;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    i_clock = 1'b0;
    i_srst = 1'b1;
    seed = 32'hE085;
    n_mismatch = 0;
    total_checks = 0;
    persistent_sector_lock = '1;
    sow = 16'hFEFF;
    st = 8'h00;
    pw_in = 64'h0;
    i_password = {$random(seed), $random(seed)};
    s = $unsigned($random(seed)) % NS;
    hw_reset(5);
    check_all();
    cmd(`SPC_CMD_VSET, 16'h0);
    cmd(`SPC_CMD_ARRERAS, 16'h0); check_all();
    hw_reset(2); check_all();
    cmd(`SPC_CMD_PPROG, 16'h0); check_all();
    cmd(`SPC_CMD_ARRPROG, 16'h0); check_all();
    cmd(`SPC_CMD_LKCLR, 16'h0);
    cmd(`SPC_CMD_PERASE, 16'h0); check_all();
    cmd(`SPC_CMD_VSET, 16'h0);
    cmd(`SPC_CMD_VCLR, 16'h0); check_all();
    cmd(`SPC_CMD_CLRST, 16'h0);
    hw_reset(2); check_all();
    cmd(`SPC_CMD_PERASE, 16'h0);
    cmd(`SPC_CMD_ARRERAS, 16'h0); check_all();
    cmd(`SPC_CMD_SOWPROG, 16'hFFF9); check_all();
    cmd(`SPC_CMD_CLRST, 16'h0);
    v = (16'($random(seed)) | 16'h0002) & 16'hFFFB;
    cmd(`SPC_CMD_SOWPROG, v); check_all();
    cmd(`SPC_CMD_SOWPROG, 16'hFFFD); check_all();
    hw_reset(2); check_all();
    cmd(`SPC_CMD_PPROG, 16'h0); check_all();
    pw(~i_password);
    cmd(`SPC_CMD_UNLOCK, 16'h0); check_all();
    pw(i_password);
    cmd(`SPC_CMD_UNLOCK, 16'h0);
    cmd(`SPC_CMD_PPROG, 16'h0); check_all();
    cmd(`SPC_CMD_LKCLR, 16'h0); check_all();
    tally_and_finish();
  end
endmodule // tb
